// >>> core/mcs_delay_chain.sv
`timescale 1ns/1ps
`include "mcs_defs.svh"
module mcs_delay_chain import mcs_pkg::*; (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic srst,
    // Start on rising modify window
    input  wire logic start,
    // Fires on fourth edge after start
    output logic      fire
);
    typedef struct packed {
        logic delay_stage_one;
        logic delay_stage_two;
        logic delay_stage_three;
        logic fire;
    } mcs_dly_st_t;

    mcs_dly_st_t st_reg;        // Registered state
    mcs_dly_st_t st_next;       // Next state
    logic        delay_chain_clear_n; // Low while stage two holds

    if (`MCS_DLY_STAGES != 3) begin : g_chk
        $error("delay chain is built for three stages");
    end

    // Stage one clears itself one edge after it sets, so one window edge fires once
    always_comb begin
        delay_chain_clear_n = ~st_reg.delay_stage_two;
        st_next = st_reg;
        st_next.delay_stage_one = start | (st_reg.delay_stage_one & delay_chain_clear_n);
        if (st_reg.delay_stage_one) begin
            st_next.delay_stage_one = 1'b0;
        end
        st_next.delay_stage_two   = st_reg.delay_stage_one;
        st_next.delay_stage_three = st_reg.delay_stage_two;
        st_next.fire              = st_reg.delay_stage_three;
        if (srst) begin
            st_next = '0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign fire = st_reg.fire;

    // Fire lands exactly on the third edge after stage one
    third_edge_a : assert property (@(posedge pclk) disable iff (!presetn || srst)
        $rose(st_reg.delay_stage_one) |-> ##3 st_reg.fire)
        else $error("second request not on third edge");
endmodule : mcs_delay_chain

// >>> core/mcs_down_counter.sv
`timescale 1ns/1ps
`include "mcs_defs.svh"
module mcs_down_counter import mcs_pkg::*; #(
    parameter int W = 12
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         srst,
    // Control
    input  wire logic         tick,
    input  wire logic         load_en,
    input  wire logic         dec_en,
    input  wire logic [W-1:0] load_val,
    // State
    output logic [W-1:0]      value,
    output logic              zero
);
    typedef struct packed {
        logic [W-1:0] cnt;      // Counter value
    } mcs_cnt_st_t;

    mcs_cnt_st_t st_reg;        // Registered state
    mcs_cnt_st_t st_next;       // Next state

    if (W < 1 || W > 16) begin : g_chk
        $error("mcs_down_counter width out of range");
    end

    // Load wins over decrement, else hold
    always_comb begin
        st_next = st_reg;
        if (srst) begin
            st_next.cnt = '0;
        end else if (tick && load_en) begin
            st_next.cnt = load_val;
        end else if (tick && dec_en) begin
            st_next.cnt = st_reg.cnt - W'(1);
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign value = st_reg.cnt;
    assign zero  = (st_reg.cnt == '0);

    // No tick and no soft reset means no change
    hold_no_tick_a : assert property (@(posedge pclk) disable iff (!presetn)
        (!tick && !srst) |=> $stable(st_reg.cnt))
        else $error("counter moved without a tick");
endmodule : mcs_down_counter

// >>> core/mcs_sequencer.sv
`timescale 1ns/1ps
`include "mcs_defs.svh"
module mcs_sequencer import mcs_pkg::*; (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Memory handshake
    input  mcs_mem_in_t      mem_in,
    output mcs_mem_out_t     mem_out,
    // Address generator controls
    output logic             addr_counter_clock,
    output logic             addr_counter_gate,
    output logic             addr_counter_load,
    output logic             cycle_strobe,
    // Transfer status
    output logic             lockout_n,
    output logic             modify_window,
    output logic             gated_data_accepted
);
    localparam int GO_LAG = (`MCS_GO_LAG_NS / `MCS_CLK_NS) < 1 ? 1
                          : (`MCS_GO_LAG_NS / `MCS_CLK_NS);

    if (GO_LAG != 1) begin : g_chk
        $error("cycle strobe lag must be one clock");
    end

    typedef struct packed {
        mcs_state_t   state;          // Sequencer state
        logic [1:0]   mode;           // Mode bits, high then low
        logic [19:0]  preload;        // Lines and line length
        logic         cycle_req;      // Cycle request latch
        logic         gate_load;      // Gate/load latch, set = count
        logic         acc;            // Counter clock pulse
        logic         go;             // Cycle strobe pulse
        logic         gda;            // Gated data accepted pulse
        logic         mwin;           // Modify window latch
        logic         dc;             // Sampled data complete
        mcs_mem_out_t mo;             // Handshake outputs
        logic         srst;           // Soft reset pulse
        logic         pready;         // Bus answer
        logic         pslverr;        // Bus error
        logic [31:0]  prdata;         // Bus read data
    } mcs_st_t;

    mcs_st_t     st_reg;              // Registered state
    mcs_st_t     st_next;             // Next state
    logic        data_complete_pulse; // Acknowledge while requesting
    logic        dc_rise;             // Complete pulse leading edge
    logic        dc_fall;             // Complete pulse trailing edge
    logic        mw_rise;             // Modify window leading edge
    logic        second_fire;         // Delay chain done
    logic        mode_low_bit;        // Counting modes
    logic        mode_high_bit;       // Read-modify-write modes
    logic [11:0] len_val;             // Line length count
    logic [7:0]  line_val;            // Line count
    logic        len_zero;            // Length at zero
    logic        line_zero;           // Lines at zero
    logic        terminal_count;      // Whole counter exhausted
    logic        term_qual;           // Termination qualifier
    logic        end_clear;           // End of cycle clear
    logic        bus_wr;              // Write taken this edge
    logic        bus_setup;           // Setup phase
    logic        mapped;              // Address decodes

    // Length counter, reloads on load control or on reaching zero
    mcs_down_counter #(.W(`MCS_LEN_W)) u_len (
        .pclk     (pclk),
        .presetn  (presetn),
        .srst     (st_reg.srst),
        .tick     (st_reg.acc),
        .load_en  (~st_reg.gate_load | len_zero),
        .dec_en   (st_reg.gate_load),
        .load_val (st_reg.preload[`MCS_LEN_W-1:0]),
        .value    (len_val),
        .zero     (len_zero)
    );

    // Line counter, decrements only on length carry
    mcs_down_counter #(.W(`MCS_LINE_W)) u_line (
        .pclk     (pclk),
        .presetn  (presetn),
        .srst     (st_reg.srst),
        .tick     (st_reg.acc),
        .load_en  (~st_reg.gate_load),
        .dec_en   (st_reg.gate_load & len_zero),
        .load_val (st_reg.preload[`MCS_LINE_POS +: `MCS_LINE_W]),
        .value    (line_val),
        .zero     (line_zero)
    );

    // Second request timing
    mcs_delay_chain u_dly (
        .pclk    (pclk),
        .presetn (presetn),
        .srst    (st_reg.srst),
        .start   (mw_rise),
        .fire    (second_fire)
    );

    // Decode and cycle-end terms
    always_comb begin
        mode_low_bit        = st_reg.mode[0];
        mode_high_bit       = st_reg.mode[1];
        data_complete_pulse = ~mem_in.data_acknowledge_n & ~st_reg.mo.data_request_n;
        dc_rise             = data_complete_pulse & ~st_reg.dc;
        dc_fall             = ~data_complete_pulse & st_reg.dc;
        // Window rises on a trailing complete edge in rmw modes, not under soft reset
        mw_rise             = dc_fall & mode_high_bit & ~st_reg.mwin & ~st_reg.srst;
        terminal_count      = line_zero & len_zero;
        // High in modes 0,2; mode 1 also on length reload
        term_qual = ~mode_low_bit | terminal_count | (~mode_high_bit & len_zero);
        end_clear = st_reg.gda & term_qual;
        bus_setup = psel & ~penable;
        bus_wr    = psel & penable & st_reg.pready & pwrite;
        mapped    = (paddr == `MCS_CTRL_OFF) || (paddr == `MCS_PRELOAD_OFF)
                 || (paddr == `MCS_STATUS_OFF) || (paddr == `MCS_COUNT_OFF);
    end

    // Sequencer, handshake and register file
    always_comb begin
        st_next      = st_reg;
        st_next.acc  = 1'b0;
        st_next.go   = 1'b0;
        st_next.gda  = 1'b0;
        st_next.srst = 1'b0;
        st_next.dc   = data_complete_pulse;
        // Lockout latch clocked by trailing edge of complete pulse
        if (dc_fall) begin
            st_next.mwin = mode_high_bit & ~st_reg.mwin;
        end
        // End clear resets both latches
        if (end_clear) begin
            st_next.cycle_req = 1'b0;
            st_next.gate_load = 1'b0;
        end
        unique case (st_reg.state)
            MCS_IDLE: begin
                // Wait for memory free and acknowledge released
                if (st_reg.cycle_req && !end_clear && mem_in.mem_busy_n
                    && !st_reg.dc && !st_reg.mwin) begin
                    st_next.acc   = 1'b1;
                    st_next.state = MCS_STROBE;
                end
            end
            MCS_STROBE: begin
                st_next.go              = 1'b1;
                st_next.gate_load       = mode_low_bit;
                st_next.mo.addr_avail_n = 1'b0;
                st_next.state           = MCS_ADDR;
            end
            MCS_ADDR: begin
                if (!mem_in.addr_accept_n) begin
                    st_next.mo.addr_avail_n   = 1'b1;
                    st_next.mo.data_request_n = 1'b0;
                    st_next.state             = MCS_DATA;
                end
            end
            MCS_DATA: begin
                if (dc_rise) begin
                    st_next.mo.data_request_n = 1'b1;
                    if (mode_high_bit) begin
                        st_next.state = MCS_GAP;
                    end else begin
                        st_next.gda   = 1'b1;
                        st_next.state = MCS_IDLE;
                    end
                end
            end
            MCS_GAP: begin
                // Memory needs time before the second request
                if (second_fire) begin
                    st_next.mo.data_request_n = 1'b0;
                    st_next.state             = MCS_DATA2;
                end
            end
            MCS_DATA2: begin
                if (dc_rise) begin
                    st_next.mo.data_request_n = 1'b1;
                    st_next.gda               = 1'b1;
                    st_next.state             = MCS_IDLE;
                end
            end
            default: begin
                st_next.state = MCS_IDLE;
            end
        endcase
        // APB: no wait states, answer registered in the setup phase
        st_next.pready = bus_setup;
        if (bus_setup) begin
            st_next.pslverr = ~mapped;
            st_next.prdata  = 32'h0;
            if (!pwrite) begin
                if (paddr == `MCS_CTRL_OFF) begin
                    st_next.prdata[1:0] = st_reg.mode;
                end else if (paddr == `MCS_PRELOAD_OFF) begin
                    st_next.prdata[19:0] = st_reg.preload;
                end else if (paddr == `MCS_STATUS_OFF) begin
                    st_next.prdata[5:0] = {~st_reg.mo.data_request_n,
                        ~st_reg.mo.addr_avail_n, st_reg.mwin,
                        st_reg.gate_load, st_reg.cycle_req, st_reg.state != MCS_IDLE};
                end else if (paddr == `MCS_COUNT_OFF) begin
                    st_next.prdata[19:0] = {line_val, len_val};
                end
            end
        end
        if (bus_wr && paddr == `MCS_CTRL_OFF) begin
            // Mode changes only when no cycle is pending
            if (!st_reg.cycle_req) begin
                st_next.mode = pwdata[`MCS_CTRL_MODE_HI:`MCS_CTRL_MODE_LO];
            end
            if (pwdata[`MCS_CTRL_START]) begin
                st_next.cycle_req = 1'b1;
            end
            if (pwdata[`MCS_CTRL_SRST]) begin
                st_next.srst = 1'b1;
            end
        end
        if (bus_wr && paddr == `MCS_PRELOAD_OFF && !st_reg.cycle_req) begin
            st_next.preload = pwdata[19:0];
        end
        // Soft reset idles the sequencer but keeps settings
        if (st_reg.srst) begin
            st_next.state     = MCS_IDLE;
            st_next.cycle_req = 1'b0;
            st_next.gate_load = 1'b0;
            st_next.mwin      = 1'b0;
            st_next.acc       = 1'b0;
            st_next.go        = 1'b0;
            st_next.gda       = 1'b0;
            st_next.mo        = '{addr_avail_n: 1'b1, data_request_n: 1'b1};
        end
    end

    // State register, rising clock only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg         <= '0;
            st_reg.state   <= MCS_IDLE;
            st_reg.mode    <= `MCS_MODE_RST;
            st_reg.preload <= `MCS_PRELOAD_RST;
            st_reg.mo      <= '{addr_avail_n: 1'b1, data_request_n: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flip-flops, addr_counter_gate and lockout_n inverted
    assign pready              = st_reg.pready;
    assign prdata              = st_reg.prdata;
    assign pslverr             = st_reg.pslverr;
    assign mem_out             = st_reg.mo;
    assign addr_counter_clock  = st_reg.acc;
    assign addr_counter_load   = st_reg.gate_load;
    assign addr_counter_gate   = ~st_reg.gate_load;
    assign cycle_strobe        = st_reg.go;
    assign lockout_n           = ~st_reg.mwin;
    assign modify_window       = st_reg.mwin;
    assign gated_data_accepted = st_reg.gda;

    strobe_after_clk_a : assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.acc && !st_reg.srst |=> st_reg.go)
        else $error("cycle strobe did not follow counter clock");
    latch_takes_mode_a : assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.go |-> st_reg.gate_load == mode_low_bit)
        else $error("gate/load latch did not take mode low bit");
    window_rmw_only_a : assert property (@(posedge pclk) disable iff (!presetn)
        !mode_high_bit && !st_reg.mwin |=> !st_reg.mwin)
        else $error("modify window rose outside rmw modes");
    window_release_a : assert property (@(posedge pclk) disable iff (!presetn)
        dc_fall && st_reg.mwin |=> !st_reg.mwin)
        else $error("modify window not released");
    end_clears_a : assert property (@(posedge pclk) disable iff (!presetn)
        end_clear && !bus_wr |=> !st_reg.cycle_req && !st_reg.gate_load)
        else $error("end clear missed a latch");
    accept_final_a : assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.gda && mode_high_bit |-> $past(st_reg.state) == MCS_DATA2)
        else $error("accepted pulse on first rmw complete");
    single_strobe_a : assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.gda && !mode_low_bit && !bus_wr |=> !st_reg.cycle_req)
        else $error("single transfer mode did not end");
    addr_before_req_a : assert property (@(posedge pclk) disable iff (!presetn)
        $fell(st_reg.mo.data_request_n) && st_reg.state == MCS_DATA
        |-> $past(st_reg.state) == MCS_ADDR)
        else $error("data request before address accepted");
endmodule : mcs_sequencer

// >>> dv/mcs_mem_model.sv
`timescale 1ns/1ps
module mcs_mem_model import mcs_pkg::*; (
    // Clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // Answer pace
    input  wire logic   slow,
    // Handshake with the sequencer
    input  mcs_mem_out_t mem_out,
    output mcs_mem_in_t  mem_in
);
    logic [1:0] wait_cnt; // Cycles a request has waited
    logic       go;       // Answer now
    logic       pending;  // A request is still unanswered

    // Slow answers wait three cycles, so the sequencer must hold its request
    assign go      = slow ? (wait_cnt == 2'h3) : 1'b1;
    assign pending = (!mem_out.addr_avail_n && mem_in.addr_accept_n)
                     || (!mem_out.data_request_n && mem_in.data_acknowledge_n);

    // Each answer falls after the wait and rises once its request is gone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_in   <= '1;
            wait_cnt <= 2'h0;
        end else begin
            mem_in.addr_accept_n      <= mem_out.addr_avail_n
                                         | (mem_in.addr_accept_n & ~go);
            mem_in.data_acknowledge_n <= mem_out.data_request_n
                                         | (mem_in.data_acknowledge_n & ~go);
            // Busy from address until the acknowledge is released
            mem_in.mem_busy_n <= mem_out.addr_avail_n & mem_out.data_request_n
                                 & mem_in.data_acknowledge_n;
            wait_cnt <= (pending && !go) ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule : mcs_mem_model

// >>> dv/tb_memory_cycle_sequencer.sv
`timescale 1ns/1ps
`include "mcs_defs.svh"
module tb_memory_cycle_sequencer import mcs_pkg::*; ;
    logic         pclk, presetn, slow;                    // Clock, reset, partner pace
    logic         psel, penable, pwrite, pready, pslverr; // Bus handshake
    logic [11:0]  paddr;                                  // Bus address
    logic [31:0]  pwdata, prdata, rd;                     // Bus data
    logic         err;                                    // Last bus error
    mcs_mem_in_t  mem_in;                                 // Partner answers
    mcs_mem_out_t mem_out;                                // Sequencer requests
    logic         acc, gate, load, strobe, lock_n, win, gda;
    logic         acc_q = 1'b0, req_q = 1'b1, win_q = 1'b0; // Previous samples
    int n_strobe = 0, n_req = 0, n_gda = 0, n_win = 0, n_load = 0;
    int dly = 0, last_dly = 0, bad_lag = 0, bad_cmp = 0;
    int miscompares = 0, n_compared = 0, s_strobe, s_req, s_gda, s_win, s_load;
    int exp_go [4] = '{1, 3, 1, 6}; // Transfers per mode for preload 0x01002
    logic [31:0] exp_cnt [4] = '{32'h01002, 32'h01000, 32'h01002, 32'h00000};

    mcs_sequencer u_mcs_sequencer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .mem_in(mem_in), .mem_out(mem_out),
        .addr_counter_clock(acc), .addr_counter_gate(gate), .addr_counter_load(load),
        .cycle_strobe(strobe), .lockout_n(lock_n), .modify_window(win),
        .gated_data_accepted(gda)
    );
    mcs_mem_model u_mcs_mem_model (
        .pclk(pclk), .presetn(presetn), .slow(slow), .mem_out(mem_out), .mem_in(mem_in)
    );

    // Pulse counters and timing watch
    always @(posedge pclk) begin
        if (presetn) begin
            if (strobe !== acc_q) bad_lag <= bad_lag + 1;
            if (gate !== ~load || win !== ~lock_n) bad_cmp <= bad_cmp + 1;
            // Cycles from window rise to the next request
            if (win && !win_q) dly <= 1;
            else if (!mem_out.data_request_n && req_q) last_dly <= dly;
            else dly <= dly + 1;
            n_strobe <= n_strobe + int'(strobe);
            n_req    <= n_req + int'(!mem_out.data_request_n && req_q);
            n_gda    <= n_gda + int'(gda);
            n_win    <= n_win + int'(win);
            n_load   <= n_load + int'(load);
        end
        acc_q <= acc;
        req_q <= mem_out.data_request_n;
        win_q <= win;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One bus transfer; holds the request until ready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Poll status until busy and cycle request both drop
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, `MCS_STATUS_OFF, 32'h0);
            n++;
        end while (rd[1:0] !== 2'h0 && n < 300);
        check("idle", 32'h0, {30'h0, rd[1:0]});
        // A hung cycle ends the run at once
        if (rd[1:0] !== 2'h0) complete_run();
    endtask : wait_idle

    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        complete_run();
    end

    initial begin
        presetn = 1'b0;
        slow = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `MCS_STATUS_OFF, 32'h0);
        check("status", 32'h0, rd);
        check("controls", 32'h3, {29'h0, load, gate, lock_n});
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped", 32'h1, {31'h0, err});
        $display("test reset and map done");
        // Every mode, slow partner in the counting modes
        for (int m = 0; m < 4; m++) begin
            slow <= m[0];
            s_strobe = n_strobe;
            s_req = n_req;
            s_gda = n_gda;
            s_win = n_win;
            s_load = n_load;
            apb(1'b1, `MCS_PRELOAD_OFF, 32'h01002);
            apb(1'b1, `MCS_CTRL_OFF, 32'h4 | m);
            wait_idle();
            check("strobes", exp_go[m], n_strobe - s_strobe);
            check("requests", exp_go[m] * (m[1] ? 2 : 1), n_req - s_req);
            check("accepted", exp_go[m], n_gda - s_gda);
            check("window", {31'h0, m[1]}, {31'h0, n_win > s_win});
            check("counting", {31'h0, m[0]}, {31'h0, n_load > s_load});
            if (m[1]) check("delay", 32'h4, last_dly);
            check("end controls", 32'h3, {29'h0, load, gate, lock_n});
            apb(1'b0, `MCS_COUNT_OFF, 32'h0);
            check("count", exp_cnt[m], rd);
            $display("test mode %0d done", m);
        end
        // Soft reset right after a counting transfer has loaded the counters
        apb(1'b1, `MCS_CTRL_OFF, 32'h5);
        apb(1'b1, `MCS_CTRL_OFF, 32'h8);
        apb(1'b0, `MCS_STATUS_OFF, 32'h0);
        check("soft status", 32'h0, rd);
        apb(1'b0, `MCS_COUNT_OFF, 32'h0);
        check("soft count", 32'h0, rd);
        apb(1'b0, `MCS_PRELOAD_OFF, 32'h0);
        check("kept preload", 32'h01002, rd);
        check("soft controls", 32'h3, {29'h0, load, gate, lock_n});
        $display("test soft reset done");
        check("strobe lag", 32'h0, bad_lag);
        check("complements", 32'h0, bad_cmp);
        complete_run();
    end
endmodule : tb_memory_cycle_sequencer

// >>> shared/mcs_defs.svh
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH
// Register byte offsets
`define MCS_CTRL_OFF     12'h000
`define MCS_PRELOAD_OFF  12'h004
`define MCS_STATUS_OFF   12'h008
`define MCS_COUNT_OFF    12'h00c
// Control field positions
`define MCS_CTRL_MODE_LO 0
`define MCS_CTRL_MODE_HI 1
`define MCS_CTRL_START   2
`define MCS_CTRL_SRST    3
// Preload split: length in low bits, lines above
`define MCS_LEN_W        12
`define MCS_LINE_W       8
`define MCS_LINE_POS     12
// Reset values
`define MCS_MODE_RST     2'h0
`define MCS_PRELOAD_RST  20'h00000
// Timing
`define MCS_CLK_NS       100
`define MCS_GO_LAG_NS    40
`define MCS_DLY_STAGES   3
`endif

// >>> shared/mcs_pkg.sv
package mcs_pkg;
    // Transfer sequencing states, gray along the usual path
    typedef enum logic [2:0] {
        MCS_IDLE   = 3'h0,
        MCS_STROBE = 3'h1,
        MCS_ADDR   = 3'h3,
        MCS_DATA   = 3'h2,
        MCS_GAP    = 3'h6,
        MCS_DATA2  = 3'h7
    } mcs_state_t;

    // Memory handshake pins toward the chassis controller
    typedef struct packed {
        logic addr_avail_n;
        logic data_request_n;
    } mcs_mem_out_t;

    typedef struct packed {
        logic addr_accept_n;
        logic data_acknowledge_n;
        logic mem_busy_n;
    } mcs_mem_in_t;
endpackage : mcs_pkg
